// *** logic/decode_pkg.sv ***
// Constants, state and carrier types for the instruction decoder
// Function
// [RQ1] Decode OR, XOR, AND byte ops; zero only
// [RQ2] Add and add-with-carry update all flags
// [RQ3] Subtract and subtract-with-borrow update all flags
// [RQ4] Rotate through carry; only carry changes
// [RQ5] Decrement/increment skip-if-zero take one or two cycles
// [RQ6] Bit ops: clear, set, test-skip clear/set
// [RQ7] Literal XOR, OR, add with their flags
// [RQ8] Load page latch from 7-bit literal
// [RQ9] Taken branch or skip adds NOP cycle
// [RQ10] Indirect access with pointer MSb adds cycle
// [RQ11] Call pushes PC plus one first
// [RQ12] Literal call loads PC low 11 bits
// [RQ13] Literal call upper PC from page latch
// [RQ14] Working-register call: PC from page and W
// [RQ15] Branch loads PC, pushes nothing, two cycles
// [RQ16] Watchdog clear zeroes counter, sets status bits
// [RQ17] Clear file writes zero, sets zero flag
// [RQ18] Clear working register, sets zero flag
// [RQ19] Complement routed by destination bit, zero flag
// [RQ20] Decrement routed by destination, zero flag only
// [RQ21] Decrement-skip on zero leaves flags unchanged
// [RQ22] Zero flag set on all-zero result
// [RQ23] Unknown opcodes are single-cycle no-operations
package decode_pkg;

	// ----------------------------------------
	// Opcode fields (bits 13:8), prefixes, bit-op codes, fixed opcodes, addresses and reset values
	// ----------------------------------------
	localparam logic [5:0] OP_ADD_WREG = 6'h07;
	localparam logic [5:0] OP_ADDC_WREG = 6'h3d;
	localparam logic [5:0] OP_SUB_WREG = 6'h02;
	localparam logic [5:0] OP_SUBB_WREG = 6'h3b;
	localparam logic [5:0] OP_AND_WREG = 6'h05;
	localparam logic [5:0] OP_OR_WREG = 6'h04;
	localparam logic [5:0] OP_XOR_WREG = 6'h06;
	localparam logic [5:0] OP_ROT_LEFT = 6'h0d;
	localparam logic [5:0] OP_ROT_RIGHT = 6'h0c;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
	localparam logic [5:0] OP_INC_SKIP = 6'h0f;
	localparam logic [5:0] OP_CLR = 6'h01;
	localparam logic [5:0] OP_COMPL = 6'h09;
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_XOR_LIT = 6'h3a;
	localparam logic [5:0] OP_OR_LIT = 6'h38;
	localparam logic [5:0] OP_ADD_LIT = 6'h3e;
	localparam logic [5:0] OP_LOAD_PAGE = 6'h31;
	localparam logic [5:0] OP_MISC = 6'h00;
	localparam logic [1:0] PFX_BIT = 2'h1;
	localparam logic [1:0] PFX_JMP = 2'h2;
	localparam logic [1:0] BIT_CLR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [1:0] BIT_TSC = 2'h2;
	localparam logic [1:0] BIT_TSS = 2'h3;
	localparam logic [13:0] INSTR_WREG_CALL = 14'h000a;
	localparam logic [13:0] INSTR_WDT_CLEAR = 14'h0064;
	localparam logic [6:0] ADDR_IND0 = 7'h00;
	localparam logic [6:0] ADDR_IND1 = 7'h01;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [7:0] W_RST = 8'h00;
	localparam logic [6:0] PAGE_RST = 7'h00;

	typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_WAIT} state_e;

	typedef struct packed {
		state_e st;
		logic [13:0] instr;
		logic [14:0] pc;
		logic [7:0] wreg;
		logic [6:0] page;
		logic c;
		logic dcarry;
		logic z;
		logic to;
		logic pdown;
		logic [1:0] extra;
		logic ready;
		logic [6:0] faddr;
		logic [7:0] fwdata;
		logic fwe;
		logic push;
		logic [14:0] push_addr;
		logic wdt_clr;
	} core_s;

	localparam core_s CORE_RST = '{st: ST_FETCH, pc: PC_RST, wreg: W_RST, page: PAGE_RST,
		ready: 1'b1, to: 1'b1, pdown: 1'b1, default: '0};

endpackage

// *** logic/instr_decoder.sv ***
// Instruction decoder and execution control for the 8-bit core
`timescale 1ns/1ps
`default_nettype none
module instr_decoder import decode_pkg::*; (
	input wire logic clk, // Core clock, 100 MHz
	input wire logic rst, // Synchronous reset, high
	input wire logic [13:0] instr_word, // Opcode from program memory
	input wire logic instr_valid, // Opcode present
	output logic instr_ready, // Decoder takes an opcode
	output logic [14:0] pc_out, // Program counter
	input wire logic [7:0] file_rdata, // Data of file_addr register
	input wire logic [1:0] ptr_msb, // Pointer MSbs for the two indirect registers
	output logic [6:0] file_addr, // File register address
	output logic [7:0] file_wdata, // File write data
	output logic file_we, // File write pulse
	output logic push_valid, // Return stack push pulse
	output logic [14:0] push_addr, // Return address pushed
	output logic [7:0] wreg_out, // Working register
	output logic [6:0] page_out, // Page latch
	output logic carry, // Carry flag
	output logic digit_carry_flag, // Digit carry flag
	output logic zero, // Zero flag
	output logic timeout_status, // Time-out status
	output logic powerdown_status, // Power-down status
	output logic wdt_clear // Watchdog and prescaler clear pulse
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Returns {carry, digit carry, sum}
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [8:0] s;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		return {s[8], lo[4], s[7:0]};
	endfunction

	core_s s_r;
	core_s s_nxt;
	logic [5:0] op;
	logic dsel;
	assign op = s_r.instr[13:8];
	assign dsel = s_r.instr[7];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [9:0] sum;
		logic [7:0] res;
		logic [7:0] bmask;
		logic route;
		logic zupd;
		logic jump;
		logic skip;
		logic fileop;
		logic ind;
		logic [14:0] target;
		sum = 10'h000;
		res = 8'h00;
		bmask = 8'h01 << s_r.instr[9:7];
		route = 1'b0;
		zupd = 1'b0;
		jump = 1'b0;
		skip = 1'b0;
		fileop = 1'b0;
		ind = 1'b0;
		target = s_r.pc;
		s_nxt = s_r;
		s_nxt.fwe = 1'b0;
		s_nxt.push = 1'b0;
		s_nxt.wdt_clr = 1'b0;
		case (s_r.st)
			ST_FETCH: begin
				if (instr_valid) begin
					s_nxt.instr = instr_word;
					s_nxt.faddr = instr_word[6:0];
					s_nxt.ready = 1'b0;
					s_nxt.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (s_r.instr[13:12] == PFX_BIT) begin
					fileop = 1'b1;
					case (s_r.instr[11:10])
						BIT_CLR: begin
							s_nxt.fwe = 1'b1; // RQ6
							s_nxt.fwdata = file_rdata & ~bmask;
						end
						BIT_SET: begin
							s_nxt.fwe = 1'b1; // RQ6
							s_nxt.fwdata = file_rdata | bmask;
						end
						BIT_TSC: skip = ((file_rdata & bmask) == 8'h00); // RQ6
						default: skip = ((file_rdata & bmask) != 8'h00); // RQ6
					endcase
				end else if (s_r.instr[13:12] == PFX_JMP) begin
					// RQ12 RQ13 RQ15
					target = {s_r.page[6:3], s_r.instr[10:0]};
					jump = 1'b1;
					if (!s_r.instr[11]) begin
						s_nxt.push = 1'b1; // RQ11
						s_nxt.push_addr = s_r.pc + 15'h0001;
					end
				end else begin
					case (op)
						OP_ADD_WREG, OP_ADDC_WREG: begin
							fileop = 1'b1;
							sum = add8(s_r.wreg, file_rdata, (op == OP_ADDC_WREG) & s_r.c); // RQ2
						end
						OP_SUB_WREG, OP_SUBB_WREG: begin
							fileop = 1'b1;
							// Carry reads as not-borrow
							sum = add8(file_rdata, ~s_r.wreg, (op == OP_SUB_WREG) | s_r.c); // RQ3
						end
						OP_AND_WREG, OP_OR_WREG, OP_XOR_WREG: begin
							fileop = 1'b1;
							route = 1'b1;
							zupd = 1'b1; // RQ1
							res = (op == OP_AND_WREG) ? (s_r.wreg & file_rdata) :
								(op == OP_OR_WREG) ? (s_r.wreg | file_rdata) :
								(s_r.wreg ^ file_rdata);
						end
						OP_ROT_LEFT: begin
							fileop = 1'b1;
							route = 1'b1;
							res = {file_rdata[6:0], s_r.c}; // RQ4
							s_nxt.c = file_rdata[7];
						end
						OP_ROT_RIGHT: begin
							fileop = 1'b1;
							route = 1'b1;
							res = {s_r.c, file_rdata[7:1]}; // RQ4
							s_nxt.c = file_rdata[0];
						end
						OP_DEC_SKIP, OP_INC_SKIP: begin
							fileop = 1'b1;
							route = 1'b1;
							res = (op == OP_DEC_SKIP) ? file_rdata - 8'h01 : file_rdata + 8'h01;
							skip = (res == 8'h00); // RQ5 RQ21
						end
						OP_COMPL, OP_DEC: begin
							fileop = 1'b1;
							route = 1'b1;
							zupd = 1'b1;
							res = (op == OP_COMPL) ? ~file_rdata : file_rdata - 8'h01; // RQ19 RQ20
						end
						OP_CLR: begin
							if (dsel) begin
								fileop = 1'b1;
								s_nxt.fwe = 1'b1; // RQ17
								s_nxt.fwdata = 8'h00;
								s_nxt.z = 1'b1;
							end else if (s_r.instr[6:2] == 5'h00) begin
								s_nxt.wreg = 8'h00; // RQ18
								s_nxt.z = 1'b1;
							end
						end
						OP_XOR_LIT, OP_OR_LIT: begin
							zupd = 1'b1; // RQ7
							res = (op == OP_XOR_LIT) ? (s_r.wreg ^ s_r.instr[7:0]) :
								(s_r.wreg | s_r.instr[7:0]);
							s_nxt.wreg = res;
						end
						OP_ADD_LIT: sum = add8(s_r.wreg, s_r.instr[7:0], 1'b0); // RQ7
						OP_LOAD_PAGE: begin
							if (dsel) begin
								s_nxt.page = s_r.instr[6:0]; // RQ8
							end
						end
						OP_MISC: begin
							if (s_r.instr == INSTR_WREG_CALL) begin
								target = {s_r.page, s_r.wreg}; // RQ14
								jump = 1'b1;
								s_nxt.push = 1'b1; // RQ11
								s_nxt.push_addr = s_r.pc + 15'h0001;
							end else if (s_r.instr == INSTR_WDT_CLEAR) begin
								s_nxt.wdt_clr = 1'b1; // RQ16
								s_nxt.to = 1'b1;
								s_nxt.pdown = 1'b1;
							end
						end
						default: ; // RQ23
					endcase
					// Arithmetic forms share one flag path
					if (op == OP_ADD_WREG || op == OP_ADDC_WREG || op == OP_SUB_WREG ||
						op == OP_SUBB_WREG || op == OP_ADD_LIT) begin
						res = sum[7:0];
						route = (op != OP_ADD_LIT);
						s_nxt.c = sum[9];
						s_nxt.dcarry = sum[8];
						zupd = 1'b1;
						if (op == OP_ADD_LIT) begin
							s_nxt.wreg = res;
						end
					end
				end
				if (route) begin
					if (dsel) begin
						s_nxt.fwe = 1'b1;
						s_nxt.fwdata = res;
					end else begin
						s_nxt.wreg = res;
					end
				end
				if (zupd) begin
					s_nxt.z = (res == 8'h00); // RQ22
				end
				// The extra cycle only applies when the pointer MSb is set
				ind = fileop && (s_r.faddr == ADDR_IND0 || s_r.faddr == ADDR_IND1) &&
					ptr_msb[s_r.faddr[0]]; // RQ10
				s_nxt.pc = jump ? target : s_r.pc + (skip ? 15'h0002 : 15'h0001);
				s_nxt.extra = {1'b0, jump | skip} + {1'b0, ind}; // RQ9
				if (jump || skip || ind) begin
					s_nxt.st = ST_WAIT;
				end else begin
					s_nxt.st = ST_FETCH;
					s_nxt.ready = 1'b1;
				end
			end
			ST_WAIT: begin
				// Stands in for the discarded or delayed instruction
				s_nxt.extra = s_r.extra - 2'h1;
				if (s_r.extra == 2'h1) begin
					s_nxt.st = ST_FETCH;
					s_nxt.ready = 1'b1;
				end
			end
			default: s_nxt = CORE_RST;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign instr_ready = s_r.ready;
	assign pc_out = s_r.pc;
	assign file_addr = s_r.faddr;
	assign file_wdata = s_r.fwdata;
	assign file_we = s_r.fwe;
	assign push_valid = s_r.push;
	assign push_addr = s_r.push_addr;
	assign wreg_out = s_r.wreg;
	assign page_out = s_r.page;
	assign carry = s_r.c;
	assign digit_carry_flag = s_r.dcarry;
	assign zero = s_r.z;
	assign timeout_status = s_r.to;
	assign powerdown_status = s_r.pdown;
	assign wdt_clear = s_r.wdt_clr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic ex;
	assign ex = (s_r.st == ST_EXEC);

	sequence one_nop_s;
		(s_r.st == ST_WAIT && !instr_ready) ##1 (s_r.st == ST_FETCH && instr_ready);
	endsequence

	sequence flags_kept_s;
		$stable(carry) && $stable(digit_carry_flag) && $stable(zero);
	endsequence

	logic_zero_a: assert property (ex && op == OP_XOR_WREG // RQ1
		|=> zero == ((dsel ? file_wdata : wreg_out) == 8'h00) && $stable(carry))
		else $error("logic op zero flag wrong");
	add_result_a: assert property (ex && op == OP_ADD_WREG // RQ2
		|=> {carry, (dsel ? file_wdata : wreg_out)} ==
		{1'b0, $past(s_r.wreg)} + {1'b0, $past(file_rdata)})
		else $error("add result or carry wrong");
	sub_carry_a: assert property (ex && op == OP_SUB_WREG // RQ3
		|=> carry == ($past(file_rdata) >= $past(s_r.wreg)))
		else $error("subtract carry wrong");
	rotate_flags_a: assert property (ex && op == OP_ROT_LEFT // RQ4
		|=> carry == $past(file_rdata[7]) && $stable(zero) && $stable(digit_carry_flag))
		else $error("rotate changed wrong flags");
	skip_nop_a: assert property (ex && op == OP_DEC_SKIP && file_rdata == 8'h01 // RQ5 RQ9 RQ21
		&& !(s_r.faddr[6:1] == 6'h00) |=> flags_kept_s ##0 one_nop_s)
		else $error("skip did not take one nop");
	bit_set_a: assert property (ex && s_r.instr[13:10] == {PFX_BIT, BIT_SET} // RQ6
		|=> file_we && file_wdata[$past(s_r.instr[9:7])])
		else $error("bit set missing");
	page_load_a: assert property (ex && op == OP_LOAD_PAGE && dsel // RQ8
		|=> page_out == $past(s_r.instr[6:0]) ##0 flags_kept_s)
		else $error("page latch load wrong");
	ind_extra_a: assert property (ex && (op == OP_COMPL || op == OP_OR_WREG) // RQ10
		&& s_r.faddr == ADDR_IND1 && ptr_msb[1] |=> one_nop_s)
		else $error("indirect extra cycle missing");
	call_push_a: assert property (ex && s_r.instr[13:11] == 3'h4 // RQ11 RQ12 RQ13
		|=> push_valid && push_addr == $past(pc_out) + 15'h0001
		&& pc_out == {page_out[6:3], $past(s_r.instr[10:0])} ##0 one_nop_s)
		else $error("literal call wrong");
	wreg_subroutine_call_pc_a: assert property (ex && s_r.instr == INSTR_WREG_CALL
		|=> push_valid && pc_out == {$past(s_r.page), $past(s_r.wreg)}) // RQ14
		else $error("call through w wrong");
	branch_a: assert property (ex && s_r.instr[13:11] == 3'h5
		|=> !push_valid && pc_out[10:0] == $past(s_r.instr[10:0]) ##0 one_nop_s) // RQ15
		else $error("branch wrong");
	wdt_a: assert property (ex && s_r.instr == INSTR_WDT_CLEAR
		|=> wdt_clear && timeout_status && powerdown_status) // RQ16
		else $error("watchdog clear wrong");
	clear_file_op_a: assert property (ex && op == OP_CLR && dsel
		|=> file_we && file_wdata == 8'h00 && zero) // RQ17
		else $error("clear file wrong");
	clear_wreg_op_a: assert property (ex && s_r.instr[13:2] == 12'h040
		|=> wreg_out == 8'h00 && zero) // RQ18
		else $error("clear w wrong");
	comp_route_a: assert property (ex && op == OP_COMPL && dsel
		|=> file_we && file_wdata == ~$past(file_rdata) && zero == (file_wdata == 8'h00)) // RQ19 RQ22
		else $error("complement wrong");
	dec_route_a: assert property (ex && op == OP_DEC && !dsel
		|=> wreg_out == $past(file_rdata) - 8'h01 && $stable(carry)) // RQ20
		else $error("decrement wrong");
	unknown_nop_a: assert property (ex && op == 6'h08
		|=> !file_we && $stable(wreg_out) && instr_ready && pc_out == $past(pc_out) + 15'h0001) // RQ23
		else $error("unknown opcode not a nop");

endmodule
`default_nettype wire

// *** test/file_regs_model.sv ***
// Data file registers and return stack watcher facing the decoder
`timescale 1ns/1ps
`default_nettype none
module file_regs_model (
	input wire logic clk, // Core clock
	input wire logic [6:0] file_addr, // Register address
	input wire logic [7:0] file_wdata, // Write data
	input wire logic file_we, // Write pulse
	input wire logic push_valid, // Stack push pulse
	input wire logic [14:0] push_addr, // Pushed return address
	input wire logic wdt_clear, // Watchdog clear pulse
	output logic [7:0] file_rdata // Read data
);
	logic [7:0] mem [128];
	logic [14:0] top_r;
	int pushes = 0;
	int clears = 0;

	// Combinational read: the decoder samples it in its execute cycle
	assign file_rdata = mem[file_addr];

	always @(posedge clk) begin
		if (file_we === 1'b1) begin
			mem[file_addr] <= file_wdata;
		end
		if (push_valid === 1'b1) begin
			top_r <= push_addr;
			pushes <= pushes + 1;
		end
		if (wdt_clear === 1'b1) begin
			clears <= clears + 1;
		end
	end
endmodule
`default_nettype wire

// *** test/instr_decoder_tb.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module instr_decoder_tb import decode_pkg::*;;
	logic clk, rst, instr_valid, instr_ready, file_we, push_valid, wdt_clear;
	logic carry, digit_carry_flag, zero, timeout_status, powerdown_status;
	logic [13:0] instr_word;
	logic [14:0] pc_out, push_addr, pc0;
	logic [7:0] file_rdata, file_wdata, wreg_out;
	logic [6:0] file_addr, page_out;
	logic [1:0] ptr_msb;
	int n_errors = 0;
	int cmp_count = 0;

	instr_decoder instr_decoder_i (.clk(clk), .rst(rst), .instr_word(instr_word),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .pc_out(pc_out),
		.file_rdata(file_rdata), .ptr_msb(ptr_msb), .file_addr(file_addr),
		.file_wdata(file_wdata), .file_we(file_we), .push_valid(push_valid),
		.push_addr(push_addr), .wreg_out(wreg_out), .page_out(page_out), .carry(carry),
		.digit_carry_flag(digit_carry_flag), .zero(zero), .timeout_status(timeout_status),
		.powerdown_status(powerdown_status), .wdt_clear(wdt_clear));

	file_regs_model file_regs_model_i (.clk(clk), .file_addr(file_addr),
		.file_wdata(file_wdata), .file_we(file_we), .push_valid(push_valid),
		.push_addr(push_addr), .wdt_clear(wdt_clear), .file_rdata(file_rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chkw(input logic [7:0] e);
		chk(15'(wreg_out), 15'(e));
	endtask

	task automatic chkf(input logic [2:0] e);
		chk(15'({carry, digit_carry_flag, zero}), 15'(e));
	endtask

	// The model stores a write pulse one edge after the decoder raises it
	task automatic chkm(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		chk(15'(file_regs_model_i.mem[a]), 15'(e));
	endtask

	task automatic setm(input logic [6:0] a, input logic [7:0] v);
		file_regs_model_i.mem[a] = v;
	endtask

	// Issues one opcode and checks the cycles until the decoder is ready again
	task automatic run(input logic [13:0] w, input int cyc);
		int n;
		n = 1;
		pc0 = pc_out;
		instr_word = w;
		instr_valid = 1'b1;
		@(posedge clk);
		#1;
		instr_valid = 1'b0;
		// Scrambled so a late sample of the word cannot pass unnoticed
		instr_word = ~w;
		while (instr_ready !== 1'b1) begin
			if (n >= 20) begin
				n_errors++;
				test_done();
			end
			@(posedge clk);
			#1;
			n++;
		end
		chk(15'(n), 15'(cyc));
	endtask

	function automatic logic [13:0] bop(input logic [5:0] o, input logic d, input logic [6:0] f);
		return {o, d, f};
	endfunction

	function automatic logic [13:0] bitop(input logic [1:0] o, input logic [2:0] b,
		input logic [6:0] f);
		return {PFX_BIT, o, b, f};
	endfunction

	task automatic setw(input logic [7:0] v);
		run(14'h0100, 2);
		run({OP_OR_LIT, v}, 2);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(pc_out, 15'h0000);
		chkw(8'h00);
		chk(15'(page_out), 15'h0000);
		chkf(3'h0);
		chk(15'({timeout_status, powerdown_status}), 15'h0003);
	endtask

	task automatic t_lit();
		run(14'h0100, 2);
		chkw(8'h00);
		chkf(3'h1);
		run({OP_OR_LIT, 8'h55}, 2);
		chkw(8'h55);
		run({OP_XOR_LIT, 8'h55}, 2);
		chkf(3'h1);
		run({OP_OR_LIT, 8'h01}, 2);
		run({OP_ADD_LIT, 8'hff}, 2);
		chkw(8'h00);
		chkf(3'h7);
	endtask

	task automatic t_byte();
		setm(7'h20, 8'h0f);
		setw(8'hf0);
		run(bop(OP_AND_WREG, 1'b0, 7'h20), 2);
		chkw(8'h00);
		chkf(3'h7);
		run(bop(OP_OR_WREG, 1'b1, 7'h20), 2);
		chkm(7'h20, 8'h0f);
		chkf(3'h6);
		setw(8'h0f);
		run(bop(OP_XOR_WREG, 1'b1, 7'h20), 2);
		chkm(7'h20, 8'h00);
		chkf(3'h7);
	endtask

	task automatic t_arith();
		setm(7'h21, 8'h08);
		setw(8'h08);
		run(bop(OP_ADD_WREG, 1'b1, 7'h21), 2);
		chkm(7'h21, 8'h10);
		chkf(3'h2);
		setm(7'h22, 8'hf8);
		run(bop(OP_ADDC_WREG, 1'b0, 7'h22), 2);
		chkw(8'h00);
		chkf(3'h7);
		setw(8'h06);
		setm(7'h23, 8'h05);
		run(bop(OP_SUB_WREG, 1'b0, 7'h23), 2);
		chkw(8'hff);
		chkf(3'h0);
		setw(8'h01);
		setm(7'h24, 8'h02);
		run(bop(OP_SUBB_WREG, 1'b1, 7'h24), 2);
		chkm(7'h24, 8'h00);
		chkf(3'h7);
	endtask

	task automatic t_rot();
		setm(7'h25, 8'h01);
		run(bop(OP_ROT_LEFT, 1'b1, 7'h25), 2);
		chkm(7'h25, 8'h03);
		chkf(3'h3);
		run(bop(OP_ROT_RIGHT, 1'b0, 7'h25), 2);
		chkw(8'h01);
		chkf(3'h7);
	endtask

	task automatic t_skip();
		run({OP_OR_LIT, 8'h01}, 2);
		setm(7'h26, 8'h02);
		run(bop(OP_DEC_SKIP, 1'b1, 7'h26), 2);
		chk(pc_out, pc0 + 15'h0001);
		chkm(7'h26, 8'h01);
		run(bop(OP_DEC_SKIP, 1'b1, 7'h26), 3);
		chk(pc_out, pc0 + 15'h0002);
		chkf(3'h6);
		setm(7'h27, 8'hff);
		run(bop(OP_INC_SKIP, 1'b0, 7'h27), 3);
		chkw(8'h00);
		chkf(3'h6);
	endtask

	task automatic t_bit();
		setm(7'h28, 8'h00);
		run(bitop(BIT_SET, 3'h7, 7'h28), 2);
		run(bitop(BIT_SET, 3'h3, 7'h28), 2);
		run(bitop(BIT_CLR, 3'h3, 7'h28), 2);
		chkm(7'h28, 8'h80);
		run(bitop(BIT_TSC, 3'h3, 7'h28), 3);
		run(bitop(BIT_TSS, 3'h3, 7'h28), 2);
		run(bitop(BIT_TSS, 3'h7, 7'h28), 3);
		run(bitop(BIT_TSC, 3'h7, 7'h28), 2);
		chkf(3'h6);
	endtask

	task automatic t_dec();
		setm(7'h29, 8'haa);
		run(bop(OP_CLR, 1'b1, 7'h29), 2);
		chkm(7'h29, 8'h00);
		chkf(3'h7);
		run(bop(OP_COMPL, 1'b0, 7'h29), 2);
		chkw(8'hff);
		chkm(7'h29, 8'h00);
		chkf(3'h6);
		run(bop(OP_COMPL, 1'b1, 7'h29), 2);
		chkm(7'h29, 8'hff);
		run(bop(OP_DEC, 1'b0, 7'h29), 2);
		chkw(8'hfe);
		chkm(7'h29, 8'hff);
		setm(7'h2a, 8'h01);
		run(bop(OP_DEC, 1'b1, 7'h2a), 2);
		chkm(7'h2a, 8'h00);
		chkf(3'h7);
	endtask

	task automatic t_jump();
		int p;
		run({OP_LOAD_PAGE, 1'b1, 7'h78}, 2);
		chk(15'(page_out), 15'h0078);
		chkf(3'h7);
		p = file_regs_model_i.pushes;
		run({PFX_JMP, 1'b0, 11'h123}, 3);
		chk(pc_out, {4'hf, 11'h123});
		chk(file_regs_model_i.top_r, pc0 + 15'h0001);
		chk(15'(file_regs_model_i.pushes), 15'(p + 1));
		run({PFX_JMP, 1'b1, 11'h7ff}, 3);
		chk(pc_out, {4'hf, 11'h7ff});
		chk(15'(file_regs_model_i.pushes), 15'(p + 1));
		setw(8'h5a);
		run(INSTR_WREG_CALL, 3);
		chk(pc_out, {7'h78, 8'h5a});
		chk(file_regs_model_i.top_r, pc0 + 15'h0001);
	endtask

	task automatic t_misc();
		int c;
		logic [5:0] ops [3] = '{6'h08, 6'h0e, 6'h37};
		c = file_regs_model_i.clears;
		run(INSTR_WDT_CLEAR, 2);
		// The clear pulse reaches the model one edge after the decoder is ready
		@(posedge clk);
		#1;
		chk(15'(file_regs_model_i.clears), 15'(c + 1));
		chk(15'({timeout_status, powerdown_status}), 15'h0003);
		setm(7'h29, 8'h3c);
		foreach (ops[i]) begin
			run(bop(ops[i], 1'b0, 7'h29), 2);
			chkw(8'h5a);
			chk(pc_out, pc0 + 15'h0001);
			chkf(3'h6);
		end
	endtask

	task automatic t_ind();
		ptr_msb = 2'b01;
		setm(7'h00, 8'h05);
		run(bop(OP_OR_WREG, 1'b0, ADDR_IND0), 3);
		ptr_msb = 2'b10;
		run(bop(OP_OR_WREG, 1'b0, ADDR_IND0), 2);
		run(bop(OP_OR_WREG, 1'b0, ADDR_IND1), 3);
		setm(7'h01, 8'h01);
		run(bop(OP_DEC_SKIP, 1'b1, ADDR_IND1), 4);
	endtask

	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		ptr_msb = 2'b00;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_lit();
		t_byte();
		t_arith();
		t_rot();
		t_skip();
		t_bit();
		t_dec();
		t_jump();
		t_misc();
		t_ind();
		test_done();
	end
endmodule
`default_nettype wire
